// ### pkg/tlvi_pkg.sv
// Constants, register map and carrier types of the vectored interrupt unit.
// Assumes one 10 MHz system clock shared with the CPU sequencer.
//
// Notes on behaviour
// - Flags sampled each cycle, polled next cycle
// - No call while equal/higher level active
// - Call only on final instruction cycle
// - Return or interrupt write delays vectoring
// - Unserviced level requests are never remembered
// - Call pushes PC only, loads vector
// - Vectors 0003H upward, eight bytes apart
// - Return-from-interrupt ends active level
// - Plain return leaves active level alone
// - Lines zero/one: level or edge type
// - Lines two/three: polarity and type bits
// - Vectoring clears only edge-mode line flags
// - Vectoring clears timer zero/one overflow flags
// - Timer two: overflow OR external edge flag
// - Serial request is receive OR transmit
// - Peripheral flags never cleared by vectoring
// - Firmware writes flags like hardware does, save level-mode line flags
// - USB request ORs event and endpoint flags
// - Per-source enables plus a global enable
// - Level one pre-empts level zero only
// - Same level resolved by slot order
package tlvi_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_AUX_ENABLE = 8'h01;
  localparam logic [7:0] OFS_EXT_CTRL = 8'h02;
  localparam logic [7:0] OFS_PRIORITY = 8'h03;
  localparam logic [7:0] OFS_AUX_PRIORITY = 8'h04;
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h05;
  localparam logic [7:0] OFS_TIMER2_CTRL = 8'h06;
  localparam logic [7:0] OFS_STATUS = 8'h07;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_TF1 = 7;
  localparam int BIT_TF0 = 5;
  localparam int BIT_IE1 = 3;
  localparam int BIT_IT1 = 2;
  localparam int BIT_IE0 = 1;
  localparam int BIT_IT0 = 0;
  localparam int BIT_IL3 = 7;
  localparam int BIT_IE3 = 5;
  localparam int BIT_IT3 = 4;
  localparam int BIT_IL2 = 3;
  localparam int BIT_IE2 = 1;
  localparam int BIT_IT2 = 0;
  localparam int BIT_T2_OVF = 7;
  localparam int BIT_T2_EXT = 6;
  localparam int BIT_T2_EXT_EN = 3;

  // Writable bits of each masked register; the rest read as zero, save the line 2/3 flags at OFS_EXT_CTRL
  localparam logic [7:0] MASK_ENABLE = 8'hBF;
  localparam logic [7:0] MASK_AUX = 8'hE1;
  localparam logic [7:0] MASK_EXT_CFG = 8'hDD;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;

  // ----------------------------------------------------------------
  // Vectors and slots
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS = 16;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;
  localparam logic [15:0] UNUSED_SLOTS = 16'h1E00;

  // CPU sequencer status, all on the system clock
  typedef struct packed {
    logic cycle_strobe;  // One pulse per instruction cycle
    logic last_cycle;    // Cycle is the instruction's final one
    logic reti;          // Return-from-interrupt executing
    logic irq_reg_write; // Instruction writes an interrupt register
  } tlvi_cpu_t;

  // Hardware call command to the sequencer
  typedef struct packed {
    logic call;          // Push PC only, then jump to addr
    logic level;         // Priority level taken
    logic [3:0] slot;    // Source slot, zero based
    logic [15:0] addr;   // Vector address
  } tlvi_call_t;

  // USB bus events and frame markers
  typedef struct packed {
    logic usb_bus_reset_flag;
    logic usb_resume_flag;
    logic usb_suspend_flag;
    logic start_of_frame_flag;
    logic auto_frame_marker_flag;
  } tlvi_usb_t;

endpackage

// ### hw/tlvi_unit.sv
// Two-level vectored interrupt unit: flag storage, polling and call.
// Assumes the CPU sequencer obeys call_out and pushes PC only, and that
// peripheral flags are cleared by firmware inside their own blocks.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module tlvi_unit
  import tlvi_pkg::*;
#(
  parameter int NUM_USB_EP = 8
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire tlvi_cpu_t cpu_in,
  output tlvi_call_t call_out,
  output logic [1:0] in_progress_out,
  input wire logic [3:0] ext_line_in,
  input wire logic timer2_external_input_in,
  input wire logic timer0_rollover_in,
  input wire logic timer1_rollover_in,
  input wire logic timer2_overflow_flag_in,
  input wire logic serial_receive_flag_in,
  input wire logic serial_transmit_flag_in,
  input wire logic spi_done_flag_in,
  input wire logic keypad_match_flag_in,
  input wire logic twowire_flag_in,
  input wire tlvi_usb_t usb_event_in,
  input wire logic [NUM_USB_EP-1:0] usb_endpoint_flag_in
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] enable_reg;     // Global and primary source enables
  logic [7:0] aux_enable_reg; // USB, two-wire, keypad, SPI enables
  logic [7:0] ext_cfg_reg;    // Polarity, enable, type of lines 2/3
  logic [7:0] priority_reg;   // Level bits of primary sources
  logic [7:0] aux_prio_reg;   // Level bits of auxiliary sources
  logic [1:0] ext01_type;     // Edge select of lines 0/1
  logic [3:0] ext_flag;       // External line request flags
  logic timer0_overflow_flag;
  logic timer1_overflow_flag;
  logic timer2_external_flag;
  logic timer2_external_input_enable;
  logic [1:0] active;         // Levels currently in service
  logic [NUM_SLOTS-1:0] req_sample; // Flags held for next poll
  logic wr_seen;              // Interrupt register write this instr
  logic [3:0] ext_s1;         // Synchroniser first stage
  logic [3:0] ext_s2;         // Synchroniser second stage
  logic [3:0] ext_act_prev;   // Last active state for edge detect
  logic t2x_s1;
  logic t2x_s2;
  logic t2x_prev;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic wr_ext_ctrl;
  logic wr_timer_ctrl;
  logic wr_timer2;
  assign wr_en = reg_wr_in & clk_en_in;
  assign wr_ext_ctrl = wr_en & (reg_addr_in == OFS_EXT_CTRL);
  assign wr_timer_ctrl = wr_en & (reg_addr_in == OFS_TIMER_CTRL);
  assign wr_timer2 = wr_en & (reg_addr_in == OFS_TIMER2_CTRL);

  // Per-line type and polarity; lines 0/1 are fixed active low
  logic [3:0] ext_type;
  logic [3:0] ext_pol;
  assign ext_type = {ext_cfg_reg[BIT_IT3], ext_cfg_reg[BIT_IT2],
                     ext01_type};
  assign ext_pol = {ext_cfg_reg[BIT_IL3], ext_cfg_reg[BIT_IL2],
                    2'b00};

  // Flag write data per line, in the register that holds it
  logic [3:0] ext_wr;
  logic [3:0] ext_wbit;
  assign ext_wr = {wr_ext_ctrl, wr_ext_ctrl, wr_timer_ctrl,
                   wr_timer_ctrl};
  assign ext_wbit = {reg_wdata_in[BIT_IE3], reg_wdata_in[BIT_IE2],
                     reg_wdata_in[BIT_IE1], reg_wdata_in[BIT_IE0]};

  // Call decision signals, defined further down
  logic call_go;
  logic [3:0] sel_slot;
  logic sel_level;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pins are asynchronous; only the second stage feeds logic
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      // Idle pins sit high; starting there avoids a false edge
      ext_s1 <= 4'hF;
      ext_s2 <= 4'hF;
      t2x_s1 <= 1'b1;
      t2x_s2 <= 1'b1;
    end else if (clk_en_in) begin
      ext_s1 <= ext_line_in;
      ext_s2 <= ext_s1;
      t2x_s1 <= timer2_external_input_in;
      t2x_s2 <= t2x_s1;
    end
  end

  // Active level per line after polarity
  logic [3:0] ext_act;
  assign ext_act = ~(ext_s2 ^ ext_pol);

  // Edge detector history
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ext_act_prev <= 4'h0;
      t2x_prev <= 1'b1;
    end else if (clk_en_in) begin
      ext_act_prev <= ext_act;
      t2x_prev <= t2x_s2;
    end
  end

  // ----------------------------------------------------------------
  // External line flags
  // ----------------------------------------------------------------
  // Edge mode: set on edge, set beats both clears. Level mode: the
  // flag mirrors the line, so a firmware write has no effect at all.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ext_flag <= 4'h0;
    end else if (clk_en_in) begin
      for (int i = 0; i < 4; i++) begin
        if (!ext_type[i]) begin
          ext_flag[i] <= ext_act[i];
        end else if (ext_act[i] && !ext_act_prev[i]) begin
          ext_flag[i] <= 1'b1;
        end else if (ext_wr[i]) begin
          ext_flag[i] <= ext_wbit[i];
        end else if (call_go && sel_slot == ext_slot(i)) begin
          ext_flag[i] <= 1'b0;
        end
      end
    end
  end

  // Slot number of external line i
  function automatic logic [3:0] ext_slot(input int i);
    logic [3:0] s;
    s = 4'h0;
    case (i)
      0: s = 4'h0;
      1: s = 4'h2;
      2: s = 4'h6;
      default: s = 4'h7;
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Timer flags
  // ----------------------------------------------------------------
  // Rollover sets win over firmware and vector clears
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
    end else if (clk_en_in) begin
      if (timer0_rollover_in) begin
        timer0_overflow_flag <= 1'b1;
      end else if (wr_timer_ctrl) begin
        timer0_overflow_flag <= reg_wdata_in[BIT_TF0];
      end else if (call_go && sel_slot == 4'h1) begin
        timer0_overflow_flag <= 1'b0;
      end
      if (timer1_rollover_in) begin
        timer1_overflow_flag <= 1'b1;
      end else if (wr_timer_ctrl) begin
        timer1_overflow_flag <= reg_wdata_in[BIT_TF1];
      end else if (call_go && sel_slot == 4'h3) begin
        timer1_overflow_flag <= 1'b0;
      end
    end
  end

  // Timer two external flag: falling edge while enabled, never
  // cleared by vectoring
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      timer2_external_flag <= 1'b0;
      timer2_external_input_enable <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_timer2) begin
        timer2_external_input_enable <= reg_wdata_in[BIT_T2_EXT_EN];
      end
      if (timer2_external_input_enable && t2x_prev && !t2x_s2) begin
        timer2_external_flag <= 1'b1;
      end else if (wr_timer2) begin
        timer2_external_flag <= reg_wdata_in[BIT_T2_EXT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      enable_reg <= RST_REG;
      aux_enable_reg <= RST_REG;
      ext_cfg_reg <= RST_REG;
      priority_reg <= RST_REG;
      aux_prio_reg <= RST_REG;
      ext01_type <= 2'b00;
    end else if (wr_en) begin
      unique case (reg_addr_in)
        OFS_ENABLE: enable_reg <= reg_wdata_in & MASK_ENABLE;
        OFS_AUX_ENABLE: aux_enable_reg <= reg_wdata_in & MASK_AUX;
        OFS_EXT_CTRL: ext_cfg_reg <= reg_wdata_in & MASK_EXT_CFG;
        OFS_PRIORITY: priority_reg <= reg_wdata_in;
        OFS_AUX_PRIORITY: aux_prio_reg <= reg_wdata_in & MASK_AUX;
        OFS_TIMER_CTRL: begin
          ext01_type <= {reg_wdata_in[BIT_IT1], reg_wdata_in[BIT_IT0]};
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr_in)
      OFS_ENABLE: rd_mux = enable_reg;
      OFS_AUX_ENABLE: rd_mux = aux_enable_reg;
      OFS_EXT_CTRL: begin
        rd_mux = ext_cfg_reg;
        rd_mux[BIT_IE3] = ext_flag[3];
        rd_mux[BIT_IE2] = ext_flag[2];
      end
      OFS_PRIORITY: rd_mux = priority_reg;
      OFS_AUX_PRIORITY: rd_mux = aux_prio_reg;
      OFS_TIMER_CTRL: begin
        rd_mux[BIT_TF1] = timer1_overflow_flag;
        rd_mux[BIT_TF0] = timer0_overflow_flag;
        rd_mux[BIT_IE1] = ext_flag[1];
        rd_mux[BIT_IT1] = ext01_type[1];
        rd_mux[BIT_IE0] = ext_flag[0];
        rd_mux[BIT_IT0] = ext01_type[0];
      end
      OFS_TIMER2_CTRL: begin
        rd_mux[BIT_T2_OVF] = timer2_overflow_flag_in;
        rd_mux[BIT_T2_EXT] = timer2_external_flag;
        rd_mux[BIT_T2_EXT_EN] = timer2_external_input_enable;
      end
      OFS_STATUS: rd_mux = {sel_slot, 1'b0, sel_level, active};
      default: rd_mux = 8'h00;
    endcase
  end

  // Data stands for the one cycle after the read strobe only
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Request vector
  // ----------------------------------------------------------------
  logic [NUM_SLOTS-1:0] req_raw;
  logic [NUM_SLOTS-1:0] slot_en;
  logic [NUM_SLOTS-1:0] slot_prio;
  logic usb_req;
  assign usb_req = (|usb_event_in) | (|usb_endpoint_flag_in);
  always_comb begin
    req_raw = 16'h0000;
    req_raw[0] = ext_flag[0];
    req_raw[1] = timer0_overflow_flag;
    req_raw[2] = ext_flag[1];
    req_raw[3] = timer1_overflow_flag;
    req_raw[4] = serial_receive_flag_in | serial_transmit_flag_in;
    req_raw[5] = timer2_overflow_flag_in | timer2_external_flag;
    req_raw[6] = ext_flag[2];
    req_raw[7] = ext_flag[3];
    req_raw[8] = spi_done_flag_in;
    req_raw[13] = keypad_match_flag_in;
    req_raw[14] = twowire_flag_in;
    req_raw[15] = usb_req;
  end
  assign slot_en = {aux_enable_reg[7:5], 4'h0, aux_enable_reg[0],
                    ext_cfg_reg[6], ext_cfg_reg[2], enable_reg[5:0]};
  assign slot_prio = {aux_prio_reg[7:5], 4'h0, aux_prio_reg[0],
                      priority_reg};

  // Sample once per instruction cycle; no history beyond one sample,
  // so a request that drops before it is taken is simply gone
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      req_sample <= 16'h0000;
    end else if (clk_en_in && cpu_in.cycle_strobe) begin
      req_sample <= req_raw;
    end
  end

  // ----------------------------------------------------------------
  // Polling and priority resolution
  // ----------------------------------------------------------------
  logic [NUM_SLOTS-1:0] pend;
  logic [NUM_SLOTS-1:0] pend_hi;
  logic [NUM_SLOTS-1:0] pend_pick;
  logic any_pend;
  logic level_blocked;
  logic instr_blocked;
  assign pend = req_sample & slot_en & ~UNUSED_SLOTS
              & {NUM_SLOTS{enable_reg[BIT_GLOBAL_EN]}};
  assign pend_hi = pend & slot_prio;
  assign pend_pick = (|pend_hi) ? pend_hi : pend;
  assign any_pend = |pend;

  // Lowest slot of the chosen level wins
  always_comb begin
    sel_slot = 4'h0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (pend_pick[i]) begin
        sel_slot = i[3:0];
      end
    end
  end
  assign sel_level = |pend_hi;

  // Equal or higher level already running blocks the call
  assign level_blocked = active[1] | (active[0] & ~sel_level);
  assign instr_blocked = cpu_in.reti | cpu_in.irq_reg_write
                       | wr_seen | reg_wr_in;
  assign call_go = clk_en_in & cpu_in.cycle_strobe & cpu_in.last_cycle
                 & any_pend & ~level_blocked & ~instr_blocked;

  // A register write or return holds off vectoring past the next
  // instruction, even when it falls on an earlier cycle of its own
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wr_seen <= 1'b0;
    end else if (clk_en_in) begin
      if (reg_wr_in || cpu_in.reti || cpu_in.irq_reg_write) begin
        wr_seen <= 1'b1;
      end else if (cpu_in.cycle_strobe && cpu_in.last_cycle) begin
        wr_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // In-progress levels
  // ----------------------------------------------------------------
  // Only return-from-interrupt retires a level; a plain return is
  // not seen here at all, which keeps the level blocked
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      active <= 2'b00;
    end else if (clk_en_in) begin
      if (call_go) begin
        active[sel_level] <= 1'b1;
      end else if (cpu_in.reti) begin
        if (active[1]) begin
          active[1] <= 1'b0;
        end else begin
          active[0] <= 1'b0;
        end
      end
    end
  end
  assign in_progress_out = active;

  // ----------------------------------------------------------------
  // Call command
  // ----------------------------------------------------------------
  // Sequencer pushes the PC alone, never the status word
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      call_out <= '0;
    end else if (clk_en_in) begin
      call_out.call <= call_go;
      if (call_go) begin
        call_out.level <= sel_level;
        call_out.slot <= sel_slot;
        call_out.addr <= VEC_BASE
          + {9'h000, sel_slot, 3'h0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_poll_edge;
    clk_en_in && cpu_in.cycle_strobe && cpu_in.last_cycle;
  endsequence

  sequence s_call_taken;
    call_go;
  endsequence

  a_call_last_cycle: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) s_call_taken |-> s_poll_edge)
    else $error("call outside final instruction cycle");

  a_level_block: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) call_go |-> !active[1]
      && !(active[0] && !sel_level))
    else $error("call while equal or higher level active");

  a_vector_addr: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) s_call_taken |=>
      call_out.call && call_out.addr == 16'h0003
        + 16'(call_out.slot) * 16'h0008)
    else $error("vector address wrong");

  a_unused_slot: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) call_go |-> !(sel_slot inside {[9:12]}))
    else $error("unused slot vectored");

  a_write_blocks: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) reg_wr_in |-> !call_go)
    else $error("call during interrupt register write");

  a_reti_retire: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) clk_en_in && cpu_in.reti && !call_go
      && active == 2'b11 |=> active == 2'b01)
    else $error("return did not retire top level");

  a_timer_clear: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) call_go && sel_slot == 4'h1
      && !timer0_rollover_in && !wr_timer_ctrl
      |=> !timer0_overflow_flag)
    else $error("timer zero flag not cleared on vector");

  a_sample_used: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) call_go |-> req_sample[sel_slot]
      && (!$past(clk_en_in && cpu_in.cycle_strobe)
        || req_sample == $past(req_raw)))
    else $error("call without prior sampled request");

  a_edge_clear: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) call_go && sel_slot == 4'h0
      && ext_type[0] && !ext_wr[0] && !(ext_act[0] && !ext_act_prev[0])
      |=> !ext_flag[0])
    else $error("edge line flag not cleared on vector");

endmodule

// ### tb/tlvi_cpu_model.sv
// CPU sequencer model: instruction cycles, final-cycle marks, returns.
// Assumes it shares clk_sys_in and sys_rst_in with the unit.
`timescale 1ns/1ps
module tlvi_cpu_model
  import tlvi_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic reti_req_in,
  input wire logic wr_in,
  output tlvi_cpu_t cpu_out
);
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic phase; // High on the final cycle of a two-cycle instruction
  logic reti_q; // Return-from-interrupt executing
  // Two-cycle instructions, so half the polls land off the final cycle
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      phase <= 1'b0;
      reti_q <= 1'b0;
    end else begin
      phase <= ~phase;
      reti_q <= reti_req_in;
    end
  end
  // A register write stands for an interrupt-register write instruction
  assign cpu_out = {~sys_rst_in, phase, reti_q, wr_in};
endmodule

// ### tb/test_tlvi_unit.sv
// Testbench of the vectored interrupt unit, driven through its ports.
// Assumes the unit and the sequencer model share one 10 MHz clock.
`timescale 1ns/1ps
module test_tlvi_unit
  import tlvi_pkg::*;
;
  logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, reti_req = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, t0_roll = 1'b0, rx = 1'b0;
  logic spi = 1'b0, kpd = 1'b0, t2_pin = 1'b1, clk_en = 1'b1, tx = 1'b0;
  logic [3:0] lines = 4'hF;
  logic [1:0] in_progress_out;
  tlvi_cpu_t cpu_in;
  tlvi_call_t call_out;
  int err_total = 0, n_tests = 0;
  tlvi_unit i_dut (.clk_sys_in, .sys_rst_in, .clk_en_in(clk_en),
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .cpu_in, .call_out, .in_progress_out, .ext_line_in(lines),
    .timer2_external_input_in(t2_pin), .timer0_rollover_in(t0_roll),
    .timer1_rollover_in(1'b0), .timer2_overflow_flag_in(1'b0),
    .serial_receive_flag_in(rx), .serial_transmit_flag_in(tx),
    .spi_done_flag_in(spi), .keypad_match_flag_in(kpd),
    .twowire_flag_in(1'b0), .usb_event_in('0), .usb_endpoint_flag_in('0));
  tlvi_cpu_model i_cpu (.clk_sys_in, .sys_rst_in, .reti_req_in(reti_req),
    .wr_in(reg_wr_in), .cpu_out(cpu_in));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 chk(17'(reg_rdata_out), 17'(e));
  endtask
  // Bounded wait for the one-cycle call pulse, then level and vector
  task automatic wait_call(input logic lvl, input logic [15:0] adr);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_in) #1;
      if (call_out.call === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      end_of_test();
    end else begin
      chk({call_out.level, call_out.addr}, {lvl, adr});
    end
  endtask
  task automatic no_call(input int n);
    repeat (n) begin
      @(posedge clk_sys_in) #1 chk(17'(call_out.call), 17'h0);
    end
  endtask
  task automatic reti(input logic [1:0] e);
    @(posedge clk_sys_in) reti_req <= 1'b1;
    @(posedge clk_sys_in) reti_req <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1 chk(17'(in_progress_out), 17'(e));
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    for (int a = 0; a < 9; a++) rd(8'(a), 8'h00);
    wr(OFS_ENABLE, 8'h82);
    @(posedge clk_sys_in) t0_roll <= 1'b1;
    @(posedge clk_sys_in) t0_roll <= 1'b0;
    wait_call(1'b0, 16'h000B);
    chk(17'(call_out.slot), 17'h1);
    rd(OFS_TIMER_CTRL, 8'h00);
    @(posedge clk_sys_in) t0_roll <= 1'b1;
    @(posedge clk_sys_in) t0_roll <= 1'b0;
    no_call(8);
    rd(OFS_TIMER_CTRL, 8'h20);
    reti(2'b00);
    wait_call(1'b0, 16'h000B);
    wr(OFS_PRIORITY, 8'h10);
    wr(OFS_ENABLE, 8'h92);
    @(posedge clk_sys_in) rx <= 1'b1;
    wait_call(1'b1, 16'h0023);
    chk(17'(in_progress_out), 17'h3);
    no_call(8);
    rx <= 1'b0;
    reti(2'b01);
    reti(2'b00);
    wr(OFS_AUX_ENABLE, 8'h21);
    wr(OFS_ENABLE, 8'h80);
    @(posedge clk_sys_in) {spi, kpd} <= 2'b11;
    wait_call(1'b0, 16'h0043);
    spi <= 1'b0;
    reti(2'b00);
    wait_call(1'b0, 16'h006B);
    kpd <= 1'b0;
    reti(2'b00);
    wr(OFS_TIMER_CTRL, 8'h01);
    wr(OFS_ENABLE, 8'h81);
    wr(OFS_TIMER_CTRL, 8'h03);
    wait_call(1'b0, 16'h0003);
    rd(OFS_TIMER_CTRL, 8'h01);
    reti(2'b00);
    wr(OFS_ENABLE, 8'h01);
    wr(OFS_TIMER_CTRL, 8'h03);
    no_call(8);
    wr(OFS_TIMER2_CTRL, 8'h08);
    wr(OFS_ENABLE, 8'hA0);
    @(posedge clk_sys_in) t2_pin <= 1'b0;
    wait_call(1'b0, 16'h002B);
    rd(OFS_TIMER2_CTRL, 8'h48);
    // Frozen clock enable: a write must not land
    @(posedge clk_sys_in) clk_en <= 1'b0;
    wr(OFS_PRIORITY, 8'hFF);
    @(posedge clk_sys_in) clk_en <= 1'b1;
    rd(OFS_PRIORITY, 8'h10);
    // Level line one: flag follows the pin, dropped request forgotten
    wr(OFS_ENABLE, 8'h84);
    reti(2'b00);
    @(posedge clk_sys_in) lines <= 4'hD;
    wait_call(1'b0, 16'h0013);
    rd(OFS_TIMER_CTRL, 8'h0B);
    lines <= 4'hF;
    no_call(3);
    rd(OFS_TIMER_CTRL, 8'h03);
    reti(2'b00);
    no_call(4);
    // Transmit flag alone raises the serial request
    wr(OFS_ENABLE, 8'h90);
    @(posedge clk_sys_in) tx <= 1'b1;
    wait_call(1'b1, 16'h0023);
    tx <= 1'b0;
    reti(2'b00);
    end_of_test();
  end
endmodule
